// file: verif/pll_pfd_gpo_vco_serial_ctrl_tb_top.sv
// self-checking bench of the detector, test pin and serial control bank
// assumes the oscillator receiver model on the aux pins and shared pin
`timescale 1ns/1ps
module pll_pfd_gpo_vco_serial_ctrl_tb_top;
    logic clk = 1'b0, arst_n = 1'b0, ref_in = 1'b0, ru = 1'b0, rdn = 1'b0, lk = 1'b0;
    ppgvsc_pkg::ppgvsc_req_t req = '0;
    ppgvsc_pkg::ppgvsc_rsp_t rsp;
    logic up, dn, lp, lp_oe, a0, a0_oe, a1, a1_oe;
    logic [9:0] vw;
    logic [3:0] vn;
    logic [31:0] rv;
    logic [11:0] cv [5] = '{12'h87A, 12'h862, 12'h812, 12'hA42, 12'h9C2};
    int n_fail = 0, cmp_count = 0, rc = 0;
    always #50 clk = ~clk;
    // reference at clk/8, well below the clk/2 limit of the sampler
    always @(posedge clk)
    begin
        rc <= rc + 1;
        if (rc % 4 == 3) ref_in <= ~ref_in;
    end
    ppgvsc_top uut (.clk(clk), .arst_n(arst_n), .axi_req(req), .axi_rsp(rsp), .ref_in(ref_in),
        .pfd_raw_up(ru), .pfd_raw_dn(rdn), .lock_detect(lk), .test_pair_in(20'h00002),
        .pfd_up(up), .pfd_dn(dn), .lock_or_serial_out_pin(lp), .lock_or_serial_out_pin_oe(lp_oe),
        .aux_pin_zero(a0), .aux_pin_zero_oe(a0_oe), .aux_pin_one(a1), .aux_pin_one_oe(a1_oe));
    ppgvsc_vco_model vco (.sclk(a1 & a1_oe), .sen(a0 & a0_oe), .sdata(lp & lp_oe),
        .word(vw), .nbits(vn));
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // one AXI4-Lite transfer; ready, valid and the answer are taken at the rising edge
    task automatic xfer(input logic wrt, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, b;
        req.awaddr <= a;
        req.araddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= wrt;
        req.wvalid <= wrt;
        req.bready <= wrt;
        req.arvalid <= !wrt;
        req.rready <= !wrt;
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            ta = wrt ? rsp.awready : rsp.arready;
            tw = rsp.wready;
            b = wrt ? rsp.bvalid : rsp.rvalid;
            rv = wrt ? {30'h0, rsp.bresp} : rsp.rdata;
            if (ta) req.awvalid <= 1'b0;
            if (ta) req.arvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (b) req.bready <= 1'b0;
            if (b) req.rready <= 1'b0;
            // one idle edge keeps the next call from re-raising what was just released
            if (b)
            begin
                @(posedge clk);
                return;
            end
        end
        n_fail++;
        $display("MISMATCH t=%0t bus timeout", $time);
        final_report();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (4) @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    function automatic logic [1:0] gexp(input logic [11:0] c, input logic [2:0] m);
        logic [1:0] r;
        r = c[3] ? {m[0], m[1]} : m[1:0];
        if (!(c[9] && !m[2])) r = r & {c[4], c[5]};
        return r | {c[7], c[8]};
    endfunction
    // serial frame: write the word, count enable high time in clk cycles, check the word
    task automatic frame(input logic [9:0] w, input int len);
        int hi;
        hi = 0;
        xfer(1'b1, 8'h30, {22'h0, w});
        for (int i = 0; i < 600 && !(hi > 0 && !a0); i++)
        begin
            @(negedge clk);
            if (a0 && a0_oe) hi++;
        end
        chk(32'(hi >= len - 2 && hi <= len + 2), 32'h1);
        if (len > 0) chk({vn, vw}, {4'hA, w});
        @(posedge clk);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rdc(8'h2C, 32'h00000872);
        rdc(8'h34, 32'h0000000A);
        rdc(8'h3C, 32'h00000000);
        rdc(8'h04, 32'h00000000);
        chk(rsp.rresp, ppgvsc_pkg::RSP_ERR);
        lk <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(8'h3C, 32'h00000001);
        $display("register test done");
        foreach (cv[k])
            for (int m = 0; m < 8; m++)
            begin
                wr(8'h2C, {20'h0, cv[k]});
                {lk, ru, rdn} <= m[2:0];
                repeat (4) @(posedge clk);
                chk({up, dn}, gexp(cv[k], m[2:0]));
                chk({lp_oe, lp & lp_oe}, {cv[k][6], cv[k][6] & lk});
            end
        $display("detector test done");
        wr(8'h34, 32'h3A);
        chk({a1, a0, a1_oe, a0_oe}, 4'hF);
        wr(8'h34, 32'h00);
        chk({a1, a0}, 2'b10);
        wr(8'h20, 32'h00);
        chk({a1_oe, a0_oe, lp_oe}, 3'b000);
        wr(8'h20, 32'h60);
        $display("test pin test done");
        frame(10'h155, 0);
        wr(8'h34, 32'h80);
        frame(10'h2B5, 80);
        wr(8'h34, 32'hC0);
        frame(10'h14A, 320);
        $display("serial test done");
        final_report();
    end
endmodule

// file: verif/ppgvsc_vco_model.sv
// receiver model of the external oscillator serial input
// assumes pins already gated by their output enables
`timescale 1ns/1ps
module ppgvsc_vco_model (
    input  wire logic       sclk,
    input  wire logic       sen,
    input  wire logic       sdata,
    output logic [9:0]      word,
    output logic [3:0]      nbits
);
    initial
    begin
        word  = 10'h000;
        nbits = 4'h0;
    end
    always @(posedge sen)
        nbits = 4'h0;
    // sample on the rising clock only while enabled, top bit first
    always @(posedge sclk)
        if (sen)
        begin
            word  = {word[8:0], sdata};
            nbits = nbits + 4'h1;
        end
endmodule

// file: verilog/ppgvsc_gate.sv
// up/down output gating of the phase detector
// assumes raw comparator results synchronous to clk
`timescale 1ns/1ps
module ppgvsc_gate (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        raw_up,
    input  wire logic        raw_dn,
    input  wire logic        locked,
    input  wire logic [11:0] ctrl,
    output logic             up,
    output logic             dn
);
    logic cmp_up;
    logic cmp_dn;
    logic open_up;
    logic open_dn;

    always_comb
    begin
        cmp_up = ctrl[ppgvsc_pkg::PFD_SWAP] ? raw_dn : raw_up;
        cmp_dn = ctrl[ppgvsc_pkg::PFD_SWAP] ? raw_up : raw_dn;
        if (ctrl[ppgvsc_pkg::PFD_MUTE])
        begin
            // unlocked: enables ignored so the loop can pull in
            open_up = locked ? ctrl[ppgvsc_pkg::PFD_UP_EN] : 1'b1;
            open_dn = locked ? ctrl[ppgvsc_pkg::PFD_DOWN_GATE] : 1'b1;
        end
        else
        begin
            open_up = ctrl[ppgvsc_pkg::PFD_UP_EN];
            open_dn = ctrl[ppgvsc_pkg::PFD_DOWN_GATE];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            up <= 1'b0;
            dn <= 1'b0;
        end
        else
        begin
            up <= ctrl[ppgvsc_pkg::PFD_FUP] | (cmp_up & open_up);
            dn <= ctrl[ppgvsc_pkg::PFD_FDN] | (cmp_dn & open_dn);
        end
    end
endmodule

// file: verilog/ppgvsc_pkg.sv
// constants, register map and carrier types of the detector/test/serial control bank
// assumes a single 10 MHz clock and an AXI4-Lite master with 8-bit byte addresses
package ppgvsc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_PAD  = 4'h8;
    localparam logic [3:0] IDX_PFD  = 4'hB;
    localparam logic [3:0] IDX_VCO  = 4'hC;
    localparam logic [3:0] IDX_TEST = 4'hD;
    localparam logic [3:0] IDX_LOCK = 4'hF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PFD_SWAP   = 3;
    localparam int PFD_UP_EN  = 4;
    localparam int PFD_DOWN_GATE = 5;
    localparam int PFD_LD_EN  = 6;
    localparam int PFD_FUP    = 7;
    localparam int PFD_FDN    = 8;
    localparam int PFD_MUTE   = 9;
    localparam int TST_SEL    = 0;
    localparam int TST_VAL    = 4;
    localparam int TST_QUART  = 6;
    localparam int TST_AUTO   = 7;
    localparam int PAD_GPIO   = 5;
    localparam int PAD_SDO    = 6;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [11:0] PFD_RST  = 12'h872;
    localparam logic [9:0]  VCO_RST  = 10'h000;
    localparam logic [7:0]  TST_RST  = 8'h0A;
    localparam logic [1:0]  PAD_RST  = 2'h3;
    localparam logic [3:0]  SEL_PFD  = 4'h1;
    localparam logic [3:0]  SEL_LAST = 4'h9;
    localparam logic [3:0]  SEL_TEST = 4'hA;
    localparam logic [3:0]  SER_LAST = 4'h9;
    localparam logic [1:0]  RSP_OK   = 2'h0;
    localparam logic [1:0]  RSP_ERR  = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_SEND = 2'b10
    } ppgvsc_ser_t;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } ppgvsc_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } ppgvsc_rsp_t;

endpackage

// file: verilog/ppgvsc_shift.sv
// serial sender of the 10-bit oscillator word
// assumes ref_in synchronous to clk and toggling slower than clk/2
`timescale 1ns/1ps
module ppgvsc_shift (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ref_in,
    input  wire logic       quarter,
    input  wire logic       start,
    input  wire logic [9:0] word,
    output logic            sclk,
    output logic            sen,
    output logic            sdata
);
    ppgvsc_pkg::ppgvsc_ser_t state;
    logic       ref_q;
    logic [1:0] div;
    logic       pend;
    logic [8:0] sr;
    logic [3:0] cnt;
    logic       lvl;
    logic       fall;
    logic       load;

    // data moves on the falling serial edge, the oscillator samples on the rising one
    assign lvl  = quarter ? div[1] : ref_q;
    assign fall = sclk & ~lvl;
    assign load = fall && state == ppgvsc_pkg::SER_IDLE && pend;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_q <= 1'b0;
            div   <= 2'h0;
            sclk  <= 1'b0;
        end
        else
        begin
            ref_q <= ref_in;
            sclk  <= lvl;
            if (ref_in && !ref_q)
                div <= div + 2'h1;
        end
    end

    // a start during a frame is kept and sent after it; set wins over clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pend <= 1'b0;
        else
            pend <= start | (pend & ~load);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ppgvsc_pkg::SER_IDLE;
            sen   <= 1'b0;
            sdata <= 1'b0;
            sr    <= 9'h000;
            cnt   <= 4'h0;
        end
        else if (fall)
        begin
            case (state)
                ppgvsc_pkg::SER_IDLE:
                    if (pend)
                    begin
                        state <= ppgvsc_pkg::SER_SEND;
                        sen   <= 1'b1;
                        sdata <= word[9];
                        sr    <= word[8:0];
                        cnt   <= 4'h0;
                    end
                ppgvsc_pkg::SER_SEND:
                    if (cnt == ppgvsc_pkg::SER_LAST)
                    begin
                        state <= ppgvsc_pkg::SER_IDLE;
                        sen   <= 1'b0;
                        sdata <= 1'b0;
                    end
                    else
                    begin
                        sdata <= sr[8];
                        sr    <= {sr[7:0], 1'b0};
                        cnt   <= cnt + 4'h1;
                    end
                default:
                    state <= ppgvsc_pkg::SER_IDLE;
            endcase
        end
    end

    sequence s_load;
        fall && state == ppgvsc_pkg::SER_IDLE && pend;
    endsequence

    sequence s_last;
        fall && state == ppgvsc_pkg::SER_SEND && cnt == ppgvsc_pkg::SER_LAST;
    endsequence

    AST_FIRST_BIT: assert property (@(posedge clk) disable iff (!arst_n)
        s_load |=> sen && sdata == $past(word[9]))
        else $error("frame did not open with the top bit");

    AST_FRAME_END: assert property (@(posedge clk) disable iff (!arst_n)
        s_last |=> !sen && state == ppgvsc_pkg::SER_IDLE)
        else $error("frame did not close after ten bits");
endmodule

// file: verilog/ppgvsc_top.sv
// register bank: detector gating, test pin mux, oscillator serial word, lock flag
// assumes an AXI4-Lite master on clk, and pin inputs synchronous to clk
//
// Overview of operation
// - swap bit one exchanges the detector inputs for a negative tuning slope
// - up enable, default one, gates the up output per mute mode
// - down enable, default one, gates the down output per mute mode
// - lock indicator enable drives the lock flag onto the shared pin
// - force-up holds the up output active regardless of comparison
// - force-down holds the down output active regardless of comparison
// - muted and locked: an enable of zero disables its output
// - muted and unlocked: both outputs pass, enables ignored
// - mute clear: enables gate their outputs at all times
// - writing the oscillator word sends it only while auto send is one
// - four-bit selector routes test pairs 0 and 2 to 9 to the two pins, selector one the detector outputs
// - selector ten, the reset value, drives the two-bit test field
// - serial clock is reference over four when selected, else reference
// - auto send puts data on shared pin, clock on pin one, enable pin zero
// - read-only status bit reports the lock flag, reset zero
// - the two aux pins drive only while their pad enable is set
// - the shared pin drives only while its own pad enable is set
`timescale 1ns/1ps
module ppgvsc_top (
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire ppgvsc_pkg::ppgvsc_req_t  axi_req,
    output ppgvsc_pkg::ppgvsc_rsp_t       axi_rsp,
    input  wire logic                     ref_in,
    input  wire logic                     pfd_raw_up,
    input  wire logic                     pfd_raw_dn,
    input  wire logic                     lock_detect,
    input  wire logic [19:0]              test_pair_in,
    output logic                          pfd_up,
    output logic                          pfd_dn,
    output logic                          lock_or_serial_out_pin,
    output logic                          lock_or_serial_out_pin_oe,
    output logic                          aux_pin_zero,
    output logic                          aux_pin_zero_oe,
    output logic                          aux_pin_one,
    output logic                          aux_pin_one_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [11:0] pfd_ctrl;
    logic [9:0]  vco_word;
    logic [7:0]  test_cfg;
    logic [1:0]  pad_en;
    logic        lock_q;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        wr_go;
    logic        start;
    logic        sclk;
    logic        sen;
    logic        sdata;
    logic [31:0] next_rdata;
    logic        rd_hit;
    logic [1:0]  next_aux;
    logic [31:0] wr_val;
    logic        wr_any;

    function automatic logic hit(input logic [7:0] a, input logic [3:0] idx);
        hit = (a == {2'h0, idx, 2'h0});
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, ppgvsc_pkg::IDX_PAD) || hit(a, ppgvsc_pkg::IDX_PFD)
              || hit(a, ppgvsc_pkg::IDX_VCO) || hit(a, ppgvsc_pkg::IDX_TEST)
              || hit(a, ppgvsc_pkg::IDX_LOCK);
    endfunction

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    assign axi_rsp.awready = !aw_held && !bvalid;
    assign axi_rsp.wready  = !w_held && !bvalid;
    assign axi_rsp.bvalid  = bvalid;
    assign axi_rsp.bresp   = bresp;
    assign wr_go           = aw_held && w_held && !bvalid;
    assign wr_any          = |w_strb;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (axi_req.awvalid && axi_rsp.awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= axi_req.awaddr;
        end
        else if (wr_go)
            aw_held <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (axi_req.wvalid && axi_rsp.wready)
        begin
            w_held <= 1'b1;
            w_data <= axi_req.wdata;
            w_strb <= axi_req.wstrb;
        end
        else if (wr_go)
            w_held <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bvalid <= 1'b0;
            bresp  <= ppgvsc_pkg::RSP_OK;
        end
        else if (wr_go)
        begin
            bvalid <= 1'b1;
            bresp  <= mapped(aw_addr) ? ppgvsc_pkg::RSP_OK : ppgvsc_pkg::RSP_ERR;
        end
        else if (axi_req.bready)
            bvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // register storage, byte lanes merged into the old value
    // ------------------------------------------------------------
    always_comb
    begin
        wr_val = 32'h0000_0000;
        wr_val[11:0] = pfd_ctrl;
        if (hit(aw_addr, ppgvsc_pkg::IDX_VCO))
            wr_val[9:0] = vco_word;
        else if (hit(aw_addr, ppgvsc_pkg::IDX_TEST))
            wr_val[7:0] = test_cfg;
        else if (hit(aw_addr, ppgvsc_pkg::IDX_PAD))
            wr_val[6:5] = pad_en;
        for (int b = 0; b < 4; b++)
        begin
            if (w_strb[b])
                wr_val[8*b +: 8] = w_data[8*b +: 8];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pfd_ctrl <= ppgvsc_pkg::PFD_RST;
            vco_word <= ppgvsc_pkg::VCO_RST;
            test_cfg <= ppgvsc_pkg::TST_RST;
            pad_en   <= ppgvsc_pkg::PAD_RST;
        end
        else if (wr_go)
        begin
            if (hit(aw_addr, ppgvsc_pkg::IDX_PFD))
                pfd_ctrl <= wr_val[11:0];
            else if (hit(aw_addr, ppgvsc_pkg::IDX_VCO))
                vco_word <= wr_val[9:0];
            else if (hit(aw_addr, ppgvsc_pkg::IDX_TEST))
                test_cfg <= wr_val[7:0];
            else if (hit(aw_addr, ppgvsc_pkg::IDX_PAD))
                pad_en <= wr_val[6:5];
        end
    end

    // a word written with auto send off is stored but never sent
    assign start = wr_go && wr_any && hit(aw_addr, ppgvsc_pkg::IDX_VCO)
                && test_cfg[ppgvsc_pkg::TST_AUTO];

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        rd_hit     = 1'b1;
        if (hit(axi_req.araddr, ppgvsc_pkg::IDX_PFD))
            next_rdata[11:0] = pfd_ctrl;
        else if (hit(axi_req.araddr, ppgvsc_pkg::IDX_VCO))
            next_rdata[9:0] = vco_word;
        else if (hit(axi_req.araddr, ppgvsc_pkg::IDX_TEST))
            next_rdata[7:0] = test_cfg;
        else if (hit(axi_req.araddr, ppgvsc_pkg::IDX_PAD))
            next_rdata[6:5] = pad_en;
        else if (hit(axi_req.araddr, ppgvsc_pkg::IDX_LOCK))
            next_rdata[0] = lock_q;
        else
            rd_hit = 1'b0;
    end

    assign axi_rsp.arready = !rvalid;
    assign axi_rsp.rvalid  = rvalid;
    assign axi_rsp.rdata   = rdata;
    assign axi_rsp.rresp   = rresp;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= ppgvsc_pkg::RSP_OK;
        end
        else if (axi_req.arvalid && axi_rsp.arready)
        begin
            rvalid <= 1'b1;
            rdata  <= next_rdata;
            rresp  <= rd_hit ? ppgvsc_pkg::RSP_OK : ppgvsc_pkg::RSP_ERR;
        end
        else if (axi_req.rready)
            rvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // lock flag and detector gating
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lock_q <= 1'b0;
        else
            lock_q <= lock_detect;
    end

    ppgvsc_gate u_gate (
        .clk    (clk),
        .arst_n (arst_n),
        .raw_up (pfd_raw_up),
        .raw_dn (pfd_raw_dn),
        .locked (lock_q),
        .ctrl   (pfd_ctrl),
        .up     (pfd_up),
        .dn     (pfd_dn)
    );

    ppgvsc_shift u_shift (
        .clk     (clk),
        .arst_n  (arst_n),
        .ref_in  (ref_in),
        .quarter (test_cfg[ppgvsc_pkg::TST_QUART]),
        .start   (start),
        .word    (vco_word),
        .sclk    (sclk),
        .sen     (sen),
        .sdata   (sdata)
    );

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    always_comb
    begin
        next_aux = 2'h0;
        if (test_cfg[ppgvsc_pkg::TST_AUTO])
            next_aux = {sclk, sen};
        else if (test_cfg[3:0] == ppgvsc_pkg::SEL_TEST)
            next_aux = test_cfg[ppgvsc_pkg::TST_VAL +: 2];
        else if (test_cfg[3:0] == ppgvsc_pkg::SEL_PFD)
            next_aux = {pfd_up, pfd_dn};
        else if (test_cfg[3:0] <= ppgvsc_pkg::SEL_LAST)
            next_aux = test_pair_in[2*test_cfg[3:0] +: 2];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aux_pin_one     <= 1'b0;
            aux_pin_zero    <= 1'b0;
            aux_pin_one_oe  <= 1'b0;
            aux_pin_zero_oe <= 1'b0;
        end
        else
        begin
            aux_pin_one     <= next_aux[1];
            aux_pin_zero    <= next_aux[0];
            aux_pin_one_oe  <= pad_en[0];
            aux_pin_zero_oe <= pad_en[0];
        end
    end

    // serial data outranks the lock flag on the shared pin
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_or_serial_out_pin    <= 1'b0;
            lock_or_serial_out_pin_oe <= 1'b0;
        end
        else
        begin
            if (test_cfg[ppgvsc_pkg::TST_AUTO])
                lock_or_serial_out_pin <= sdata;
            else
                lock_or_serial_out_pin <= lock_q && pfd_ctrl[ppgvsc_pkg::PFD_LD_EN];
            lock_or_serial_out_pin_oe <= pad_en[1] && (test_cfg[ppgvsc_pkg::TST_AUTO]
                                      || pfd_ctrl[ppgvsc_pkg::PFD_LD_EN]);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_FORCE_UP: assert property (
        pfd_ctrl[ppgvsc_pkg::PFD_FUP] |=> pfd_up)
        else $error("forced up output not active");

    AST_FORCE_DN: assert property (
        pfd_ctrl[ppgvsc_pkg::PFD_FDN] |=> pfd_dn)
        else $error("forced down output not active");

    AST_MUTE_LOCKED: assert property (
        pfd_ctrl[ppgvsc_pkg::PFD_MUTE] && lock_q && !pfd_ctrl[ppgvsc_pkg::PFD_UP_EN]
        && !pfd_ctrl[ppgvsc_pkg::PFD_FUP] |=> !pfd_up)
        else $error("up output not muted while locked");

    AST_UNLOCKED_PASS: assert property (
        pfd_ctrl[ppgvsc_pkg::PFD_MUTE] && !lock_q && !pfd_ctrl[ppgvsc_pkg::PFD_SWAP]
        && pfd_raw_dn |=> pfd_dn)
        else $error("down output blocked while unlocked");

    AST_DIRECT_GATE: assert property (
        !pfd_ctrl[ppgvsc_pkg::PFD_MUTE] && !pfd_ctrl[ppgvsc_pkg::PFD_DOWN_GATE]
        && !pfd_ctrl[ppgvsc_pkg::PFD_FDN] |=> !pfd_dn)
        else $error("disabled down output active");

    AST_SWAP: assert property (
        pfd_ctrl[ppgvsc_pkg::PFD_SWAP] && pfd_raw_dn && !pfd_raw_up
        && !pfd_ctrl[ppgvsc_pkg::PFD_MUTE] && pfd_ctrl[ppgvsc_pkg::PFD_UP_EN]
        && pfd_ctrl[ppgvsc_pkg::PFD_DOWN_GATE] && !pfd_ctrl[ppgvsc_pkg::PFD_FDN]
        |=> pfd_up && !pfd_dn)
        else $error("swapped inputs not exchanged");

    AST_LOCK_READ: assert property (
        axi_req.arvalid && axi_rsp.arready && hit(axi_req.araddr, ppgvsc_pkg::IDX_LOCK)
        |=> rvalid && rdata == {31'h0, $past(lock_q)})
        else $error("lock status read mismatch");

    AST_TEST_FIELD: assert property (
        !test_cfg[ppgvsc_pkg::TST_AUTO] && test_cfg[3:0] == ppgvsc_pkg::SEL_TEST
        |=> {aux_pin_one, aux_pin_zero} == $past(test_cfg[5:4]))
        else $error("test field not on aux pins");

    AST_AUTO_PINS: assert property (
        test_cfg[ppgvsc_pkg::TST_AUTO] |=> aux_pin_one == $past(sclk)
        && aux_pin_zero == $past(sen) && lock_or_serial_out_pin == $past(sdata))
        else $error("serial signals not on pins");

    AST_PAD_GATE: assert property (
        !pad_en[0] |=> !aux_pin_one_oe && !aux_pin_zero_oe)
        else $error("aux pins driven with pads off");

    AST_SDO_GATE: assert property (
        !pad_en[1] |=> !lock_or_serial_out_pin_oe)
        else $error("shared pin driven with pad off");

    AST_AUTO_START: assert property (
        wr_go && hit(aw_addr, ppgvsc_pkg::IDX_VCO) && !test_cfg[ppgvsc_pkg::TST_AUTO]
        |-> !start)
        else $error("word sent with auto send off");
endmodule
